// file: hdl/lhcsr_top.v
/*
  Host control/status register front end of the LAN function: status and
  command words, general pointer, PORT function, PHY management control and
  the receive DMA byte count.
  Assumes a single-cycle register port on i_ref_clk and a core that reports
  unit events as one-cycle pulses on the same clock.
*/
`timescale 1ns/1ps
`include "lhcsr_regs.vh"

// Functional notes
// - Set CX on interrupting command completion
// - Set frame flag when reception completes
// - Set idle flag when command unit stops
// - Set stop flag when receiver leaves ready
// - Set management flag per cycle end
// - Set soft flag on software request
// - Status bit 8 shows pause indication
// - Unit states in status; reserved bits zero
// - Specific mask bits block matching interrupts
// - Writing SI one raises interrupt
// - Global mask overrides all LAN interrupt sources
// - Unit command fields passed to units
// - General pointer accompanies unit commands
// - PORT low nibble selects function
// - Management enable gates end-of-cycle interrupt
// - Ready set on completion, cleared by command
// - Opcode 01 writes, 10 reads PHY
// - PHY and register address fields
// - Data shifted out or in serially
// - Count receive bytes moved by DMA
// - LAN and modem share interrupt pin
module lhcsr_top (
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire i_wr_en,
  input wire i_rd_en,
  input wire [5:0] i_addr,
  input wire [31:0] i_wdata,
  input wire [3:0] i_be,
  output reg [31:0] o_rdata,
  output reg o_rd_valid,
  input wire i_cu_cmd_irq_done,
  input wire i_rx_frame_done,
  input wire [1:0] i_cu_state,
  input wire [3:0] i_rx_state,
  input wire i_pause,
  input wire i_cmd_taken,
  output reg [3:0] o_cu_cmd,
  output reg [3:0] o_rx_cmd,
  output reg o_unit_cmd_strobe,
  output reg [31:0] o_gen_ptr,
  input wire i_rx_dma_valid,
  input wire [2:0] i_rx_dma_bytes,
  output reg o_port_soft_reset,
  output reg o_port_self_test,
  output reg o_port_sel_reset,
  output reg o_port_dump,
  output reg [27:0] o_port_arg,
  input wire i_modem_irq,
  output wire o_int_line_o,
  output wire o_int_line_oe,
  output wire o_lan_irq,
  output wire o_mdc,
  input wire i_mdio_i,
  output wire o_mdio_o,
  output wire o_mdio_oe
);

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  function hit;
    input [5:0] addr;
    input [5:0] ofs;
    begin
      hit = (addr[5:2] == ofs[5:2]);
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0] be;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (be[k]) begin
          merge[k*8 +: 8] = wd[k*8 +: 8];
        end
      end
    end
  endfunction

  wire wr_sysctl = i_wr_en & hit(i_addr, `LHCSR_OFS_SYSCTL);
  wire wr_gptr = i_wr_en & hit(i_addr, `LHCSR_OFS_GPTR);
  wire wr_port = i_wr_en & hit(i_addr, `LHCSR_OFS_PORT);
  wire wr_mgmt = i_wr_en & hit(i_addr, `LHCSR_OFS_MGMT);

  // ----------------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------------
  reg [1:0] cu_state_q_r;
  reg [3:0] rx_state_q_r;
  wire mg_done;

  wire cu_idle_evt = (cu_state_q_r == `LHCSR_CUS_ACTIVE) &
                     (i_cu_state != `LHCSR_CUS_ACTIVE);
  wire rx_stop_evt = (rx_state_q_r == `LHCSR_RXS_READY) &
                     (i_rx_state != `LHCSR_RXS_READY);
  wire soft_evt = wr_sysctl & i_be[3] & i_wdata[`LHCSR_CMD_SI];

  // Event flags, status bits 15 down to 10
  wire [5:0] flag_set = {i_cu_cmd_irq_done,
                         i_rx_frame_done,
                         cu_idle_evt,
                         rx_stop_evt,
                         mg_done,
                         soft_evt};
  wire [5:0] flag_clr = (wr_sysctl & i_be[1]) ? i_wdata[`LHCSR_ST_CX:`LHCSR_ST_SOFT] : 6'h00;

  reg [5:0] flags_r;
  reg [5:0] flags_nxt;

  always @* begin
    // A set in the same cycle as the acknowledge wins
    flags_nxt = (flags_r & ~flag_clr) | flag_set;
  end

  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      flags_r <= `LHCSR_FLAGS_RST;
      cu_state_q_r <= 2'h0;
      rx_state_q_r <= 4'h0;
    end else begin
      flags_r <= flags_nxt;
      cu_state_q_r <= i_cu_state;
      rx_state_q_r <= i_rx_state;
    end
  end

  // ----------------------------------------------------------------------
  // Command word, general pointer
  // ----------------------------------------------------------------------
  reg [5:0] evt_mask_r;
  reg gmask_r;

  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      evt_mask_r <= `LHCSR_MASK_RST;
      gmask_r <= `LHCSR_GMASK_RST;
      o_cu_cmd <= 4'h0;
      o_rx_cmd <= 4'h0;
      o_unit_cmd_strobe <= 1'b0;
      o_gen_ptr <= 32'h00000000;
    end else begin
      o_unit_cmd_strobe <= 1'b0;
      if (wr_sysctl & i_be[3]) begin
        evt_mask_r <= i_wdata[31:26];
        gmask_r <= i_wdata[`LHCSR_CMD_M];
      end
      if (wr_sysctl & i_be[2]) begin
        // Fields stay until the units accept them; a new write wins
        o_cu_cmd <= i_wdata[23:20];
        o_rx_cmd <= i_wdata[19:16];
        o_unit_cmd_strobe <= 1'b1;
      end else if (i_cmd_taken) begin
        o_cu_cmd <= 4'h0;
        o_rx_cmd <= 4'h0;
      end
      if (wr_gptr) begin
        o_gen_ptr <= merge(o_gen_ptr, i_wdata, i_be);
      end
    end
  end

  // ----------------------------------------------------------------------
  // PORT function
  // ----------------------------------------------------------------------
  function is_sel;
    input [3:0] sel;
    input [3:0] code;
    begin
      is_sel = (sel == code);
    end
  endfunction

  // Only a full word write launches a function, so arg and selector agree
  wire port_go = wr_port & (i_be == 4'hf);

  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_port_soft_reset <= 1'b0;
      o_port_self_test <= 1'b0;
      o_port_sel_reset <= 1'b0;
      o_port_dump <= 1'b0;
      o_port_arg <= 28'h0000000;
    end else begin
      o_port_soft_reset <= port_go & is_sel(i_wdata[3:0], `LHCSR_PORT_SWRST);
      o_port_self_test <= port_go & is_sel(i_wdata[3:0], `LHCSR_PORT_SELFTEST);
      o_port_sel_reset <= port_go & is_sel(i_wdata[3:0], `LHCSR_PORT_SELRST);
      o_port_dump <= port_go & is_sel(i_wdata[3:0], `LHCSR_PORT_DUMP);
      if (port_go) begin
        o_port_arg <= i_wdata[31:4];
      end
    end
  end

  // ----------------------------------------------------------------------
  // PHY management control
  // ----------------------------------------------------------------------
  reg mg_ie_r;
  reg mg_rdy_r;
  reg [1:0] mg_op_r;
  reg [4:0] mg_phy_r;
  reg [4:0] mg_reg_r;
  reg [15:0] mg_data_r;
  reg mg_start_r;
  wire mg_busy;
  wire [15:0] mg_rdata;
  wire mdio_sync;

  wire mg_op_ok = (i_wdata[27:26] == `LHCSR_OP_WRITE) |
                  (i_wdata[27:26] == `LHCSR_OP_READ);
  // Writes during a transfer, done cycle included, are dropped
  wire mg_take = wr_mgmt & (i_be == 4'hf) & ~mg_busy & ~mg_start_r & ~mg_done;

  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      mg_ie_r <= 1'b0;
      mg_rdy_r <= 1'b0;
      mg_op_r <= 2'h0;
      mg_phy_r <= 5'h00;
      mg_reg_r <= 5'h00;
      mg_data_r <= 16'h0000;
      mg_start_r <= 1'b0;
    end else begin
      mg_start_r <= mg_take & mg_op_ok;
      if (mg_take) begin
        mg_ie_r <= i_wdata[`LHCSR_MG_IE];
        mg_rdy_r <= 1'b0;
        mg_op_r <= i_wdata[27:26];
        mg_phy_r <= i_wdata[25:21];
        mg_reg_r <= i_wdata[20:16];
        mg_data_r <= i_wdata[15:0];
      end else if (mg_done) begin
        mg_rdy_r <= 1'b1;
        if (mg_op_r == `LHCSR_OP_READ) begin
          mg_data_r <= mg_rdata;
        end
      end
    end
  end

  lhcsr_sync #(
    .W(1)
  ) u_mdio_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_async(i_mdio_i),
    .o_sync(mdio_sync)
  );

  lhcsr_mgmt u_mgmt (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_start(mg_start_r),
    .i_op(mg_op_r),
    .i_phy_addr(mg_phy_r),
    .i_reg_addr(mg_reg_r),
    .i_wdata(mg_data_r),
    .i_mdio_sync(mdio_sync),
    .o_busy(mg_busy),
    .o_done(mg_done),
    .o_rdata(mg_rdata),
    .o_mdc(o_mdc),
    .o_mdio_o(o_mdio_o),
    .o_mdio_oe(o_mdio_oe)
  );

  // ----------------------------------------------------------------------
  // Receive DMA byte count
  // ----------------------------------------------------------------------
  reg [31:0] rx_cnt_r;

  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      rx_cnt_r <= 32'h00000000;
    end else if (i_rx_dma_valid) begin
      rx_cnt_r <= rx_cnt_r + {29'h0, i_rx_dma_bytes};
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------------
  // Management flag only interrupts when its own enable is set
  wire [5:0] irq_src = flags_r & ~evt_mask_r &
                       {4'hf, mg_ie_r, 1'b1};
  assign o_lan_irq = (|irq_src) & ~gmask_r;
  // Open-drain shared line: only ever pulled low
  assign o_int_line_o = 1'b0;
  assign o_int_line_oe = o_lan_irq | i_modem_irq;

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  wire [15:0] status_word = {flags_r, 1'b0, i_pause, i_cu_state,
                             i_rx_state, 2'b00};
  wire [15:0] command_word = {evt_mask_r, 1'b0, gmask_r, o_cu_cmd, o_rx_cmd};
  wire [31:0] mgmt_word = {2'b00, mg_ie_r, mg_rdy_r, mg_op_r, mg_phy_r,
                           mg_reg_r, mg_data_r};

  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h00000000;
    if (hit(i_addr, `LHCSR_OFS_SYSCTL)) begin
      rd_mux = {command_word, status_word};
    end else if (hit(i_addr, `LHCSR_OFS_GPTR)) begin
      rd_mux = o_gen_ptr;
    end else if (hit(i_addr, `LHCSR_OFS_MGMT)) begin
      rd_mux = mgmt_word;
    end else if (hit(i_addr, `LHCSR_OFS_RXCNT)) begin
      rd_mux = rx_cnt_r;
    end
  end

  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h00000000;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_en;
      if (i_rd_en) begin
        o_rdata <= rd_mux;
      end
    end
  end

endmodule

// file: hdl/lhcsr_regs.vh
/*
  Offsets, field positions, reset values and timing counts of the LAN host
  control/status register front end.
  Assumes a 40 MHz reference clock and a byte-addressed register port.
*/
`ifndef LHCSR_REGS_VH
`define LHCSR_REGS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define LHCSR_OFS_SYSCTL 6'h00
`define LHCSR_OFS_GPTR 6'h04
`define LHCSR_OFS_PORT 6'h08
`define LHCSR_OFS_MGMT 6'h10
`define LHCSR_OFS_RXCNT 6'h14

// ----------------------------------------------------------------------
// Status word fields
// ----------------------------------------------------------------------
`define LHCSR_ST_CX 15
`define LHCSR_ST_RXFRAME 14
`define LHCSR_ST_CUIDLE 13
`define LHCSR_ST_RXSTOP 12
`define LHCSR_ST_PHYMG 11
`define LHCSR_ST_SOFT 10
`define LHCSR_ST_PAUSE 8
`define LHCSR_FLAGS_RST 6'h00

// ----------------------------------------------------------------------
// Command word fields
// ----------------------------------------------------------------------
`define LHCSR_CMD_SI 25
`define LHCSR_CMD_M 24
`define LHCSR_MASK_RST 6'h00
`define LHCSR_GMASK_RST 1'b1

// ----------------------------------------------------------------------
// Unit state codes and PORT selectors
// ----------------------------------------------------------------------
`define LHCSR_CUS_ACTIVE 2'h2
`define LHCSR_RXS_READY 4'h4
`define LHCSR_PORT_SWRST 4'h0
`define LHCSR_PORT_SELFTEST 4'h1
`define LHCSR_PORT_SELRST 4'h2
`define LHCSR_PORT_DUMP 4'h3

// ----------------------------------------------------------------------
// Management control fields and timing
// ----------------------------------------------------------------------
`define LHCSR_MG_IE 29
`define LHCSR_MG_RDY 28
`define LHCSR_OP_WRITE 2'h1
`define LHCSR_OP_READ 2'h2
`define LHCSR_CLK_PERIOD_NS 25
`define LHCSR_MDC_MIN_PERIOD_NS 400
`define LHCSR_MDC_HALF ((`LHCSR_MDC_MIN_PERIOD_NS / 2 + `LHCSR_CLK_PERIOD_NS - 1) / `LHCSR_CLK_PERIOD_NS)
`define LHCSR_FRAME_BITS 64
`define LHCSR_RD_TURN_BIT 46

`endif

// file: hdl/lhcsr_sync.v
/*
  Two-flop synchroniser for a bus of independent level inputs.
  Assumes each bit is a slow level; no word coherence is promised.
*/
`timescale 1ns/1ps
module lhcsr_sync #(
  parameter W = 1
) (
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      reg meta_r;
      reg sync_r;
      always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end else begin
          meta_r <= i_async[g];
          sync_r <= meta_r;
        end
      end
      assign o_sync[g] = sync_r;
    end
  endgenerate
endmodule

// file: hdl/lhcsr_mgmt.v
/*
  Serial PHY management engine: one 64-bit frame per start pulse.
  Assumes the data input is already synchronised to i_ref_clk.
*/
`timescale 1ns/1ps
`include "lhcsr_regs.vh"
module lhcsr_mgmt (
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire i_start,
  input wire [1:0] i_op,
  input wire [4:0] i_phy_addr,
  input wire [4:0] i_reg_addr,
  input wire [15:0] i_wdata,
  input wire i_mdio_sync,
  output wire o_busy,
  output reg o_done,
  output reg [15:0] o_rdata,
  output reg o_mdc,
  output wire o_mdio_o,
  output wire o_mdio_oe
);
  localparam ST_IDLE = 2'b01;
  localparam ST_RUN = 2'b10;
  localparam [31:0] HALF_FULL = `LHCSR_MDC_HALF - 1;
  localparam [31:0] LAST_FULL = `LHCSR_FRAME_BITS - 1;
  localparam [31:0] TURN_FULL = `LHCSR_RD_TURN_BIT;
  localparam [3:0] HALF_LAST = HALF_FULL[3:0];
  localparam [5:0] LAST_BIT = LAST_FULL[5:0];
  localparam [5:0] TURN_BIT = TURN_FULL[5:0];

  reg [1:0] state_r;
  reg [3:0] half_r;
  reg [5:0] bit_r;
  reg [63:0] sh_r;
  reg is_read_r;

  assign o_busy = state_r[1];
  assign o_mdio_o = sh_r[63];
  // Read frames release the line from the turnaround onward
  assign o_mdio_oe = o_busy & (~is_read_r | (bit_r < TURN_BIT));

  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      state_r <= ST_IDLE;
      half_r <= 4'h0;
      bit_r <= 6'h00;
      sh_r <= 64'h0;
      is_read_r <= 1'b0;
      o_done <= 1'b0;
      o_rdata <= 16'h0000;
      o_mdc <= 1'b0;
    end else begin
      o_done <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (i_start) begin
            sh_r <= {32'hffffffff, 2'b01, i_op, i_phy_addr, i_reg_addr, 2'b10, i_wdata};
            is_read_r <= (i_op == `LHCSR_OP_READ);
            bit_r <= 6'h00;
            half_r <= 4'h0;
            o_mdc <= 1'b0;
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (half_r == HALF_LAST) begin
            half_r <= 4'h0;
            o_mdc <= ~o_mdc;
            if (!o_mdc) begin
              // Rising edge: last sixteen samples form the read data
              o_rdata <= {o_rdata[14:0], i_mdio_sync};
            end else if (bit_r == LAST_BIT) begin
              o_done <= 1'b1;
              state_r <= ST_IDLE;
            end else begin
              bit_r <= bit_r + 6'h01;
              sh_r <= {sh_r[62:0], 1'b1};
            end
          end else begin
            half_r <= half_r + 4'h1;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule

// file: testbench/lhcsr_chk.sv
/*
  Port checker of the LAN host register front end.
  Assumes binding into lhcsr_top, which has ports of the same names.
*/
`timescale 1ns/1ps
`include "lhcsr_regs.vh"
module lhcsr_chk (
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire i_wr_en,
  input wire i_rd_en,
  input wire [5:0] i_addr,
  input wire [31:0] i_wdata,
  input wire [3:0] i_be,
  input wire [31:0] o_rdata,
  input wire o_rd_valid,
  input wire [1:0] i_cu_state,
  input wire [3:0] i_rx_state,
  input wire i_pause,
  input wire i_cmd_taken,
  input wire [3:0] o_cu_cmd,
  input wire [3:0] o_rx_cmd,
  input wire o_unit_cmd_strobe,
  input wire [31:0] o_gen_ptr,
  input wire o_port_soft_reset,
  input wire o_port_dump,
  input wire [27:0] o_port_arg,
  input wire i_modem_irq,
  input wire o_int_line_o,
  input wire o_int_line_oe,
  input wire o_lan_irq,
  input wire o_mdc
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);
  wire sysctl_wr = i_wr_en && i_addr == `LHCSR_OFS_SYSCTL;
  wire port_wr = i_wr_en && i_addr == `LHCSR_OFS_PORT && i_be == 4'hf;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_global_mask_irq: assert property (sysctl_wr && i_be[3] && i_wdata[24] |=> !o_lan_irq)
    else $error("irq with global mask set");
  a_soft_irq_raise: assert property (sysctl_wr && i_be[3] && i_wdata[25] && !i_wdata[24]
    && !i_wdata[26] |=> o_lan_irq) else $error("soft irq not raised");
  a_shared_pin: assert property (o_int_line_oe == (o_lan_irq || i_modem_irq) && !o_int_line_o)
    else $error("shared pin wrong");
  a_port_reset_sel: assert property (port_wr && i_wdata[3:0] == `LHCSR_PORT_SWRST
    |=> o_port_soft_reset && o_port_arg == $past(i_wdata[31:4])) else $error("port reset lost");
  a_unit_cmd_load: assert property (sysctl_wr && i_be[2] && !i_cmd_taken |=> o_unit_cmd_strobe
    && {o_cu_cmd, o_rx_cmd} == $past(i_wdata[23:16])) else $error("unit command lost");
  a_gen_ptr_load: assert property (i_wr_en && i_addr == `LHCSR_OFS_GPTR && i_be == 4'hf
    |=> o_gen_ptr == $past(i_wdata)) else $error("pointer not loaded");
  a_status_fields: assert property (i_rd_en && i_addr == `LHCSR_OFS_SYSCTL |=> o_rd_valid
    && o_rdata[9:0] == {1'b0, $past(i_pause), $past(i_cu_state), $past(i_rx_state), 2'h0})
    else $error("status fields wrong");
  a_mdc_half_period: assert property ($rose(o_mdc) |=> o_mdc [*7] ##1 !o_mdc)
    else $error("mdc high time wrong");
  cover property (o_port_dump);
  cover property (o_lan_irq && o_int_line_oe);
  cover property ($rose(o_mdc));
endmodule
bind lhcsr_top lhcsr_chk u_lhcsr_chk (.*);

// file: testbench/lhcsr_phy.sv
/*
  Behavioural PHY on the serial management link.
  Assumes the bench arms it before each frame and resolves the pin.
*/
`timescale 1ns/1ps
module lhcsr_phy (
  input wire i_arm,
  input wire i_mdc,
  input wire i_line,
  input wire [15:0] i_rd_data,
  output reg o_drv_oe,
  output reg o_drv,
  output reg [0:63] o_frame,
  output reg [6:0] o_bits
);
  wire is_rd = o_frame[34:35] == 2'h2;
  initial begin
    o_drv_oe = 1'b0;
    o_drv = 1'b1;
    o_frame = 64'h0;
    o_bits = 7'h0;
  end
  // ----------------------------------------------------------------
  // Capture on the rise, answer after the fall
  // ----------------------------------------------------------------
  always @(posedge i_mdc or posedge i_arm) begin
    if (i_arm)
      o_bits <= 7'h0;
    else begin
      o_frame[o_bits[5:0]] <= i_line;
      o_bits <= o_bits + 7'h1;
    end
  end
  // Released after bit 63 so the pull-up owns the idle line
  always @(negedge i_mdc) begin
    o_drv_oe <= is_rd && o_bits >= 7'h2f && o_bits <= 7'h3f;
    o_drv <= (o_bits == 7'h2f) ? 1'b0 : i_rd_data[7'h3f - o_bits];
  end
endmodule

// file: testbench/lan_host_control_status_regs_tb.sv
/*
  Self-checking bench of the host register front end with a PHY model.
  Assumes the design files and lhcsr_regs.vh on the include path.
*/
`timescale 1ns/1ps
`include "lhcsr_regs.vh"
module lan_host_control_status_regs_tb;
  reg i_ref_clk = 1'b0, i_rst_n = 1'b0, i_wr_en = 1'b0, i_rd_en = 1'b0, arm = 1'b0;
  reg i_cu_cmd_irq_done = 1'b0, i_rx_frame_done = 1'b0, i_pause = 1'b0, i_cmd_taken = 1'b0;
  reg i_rx_dma_valid = 1'b0, i_modem_irq = 1'b0;
  reg [1:0] i_cu_state = 2'h2;
  reg [3:0] i_rx_state = 4'h4, i_be = 4'h0;
  reg [5:0] i_addr = 6'h00;
  reg [2:0] i_rx_dma_bytes = 3'h0;
  reg [31:0] i_wdata = 32'h0, rv = 32'h0;
  reg [15:0] rd_dat = 16'h3c96;
  integer mismatches = 0, checks_done = 0, cyc = 0, k;
  wire [31:0] o_rdata, o_gen_ptr;
  wire [3:0] o_cu_cmd, o_rx_cmd;
  wire [27:0] o_port_arg;
  wire o_rd_valid, o_unit_cmd_strobe, o_port_soft_reset, o_port_self_test, o_port_sel_reset;
  wire o_port_dump, o_int_line_o, o_int_line_oe, o_lan_irq, o_mdc, o_mdio_o, o_mdio_oe;
  wire phy_oe, phy_d;
  wire [0:63] frame;
  wire mdio_line = o_mdio_oe ? o_mdio_o : (phy_oe ? phy_d : 1'b1);

  lhcsr_top u_lhcsr_top (.*, .i_mdio_i(mdio_line));
  lhcsr_phy u_lhcsr_phy (.i_arm(arm), .i_mdc(o_mdc), .i_line(mdio_line), .i_rd_data(rd_dat),
    .o_drv_oe(phy_oe), .o_drv(phy_d), .o_frame(frame), .o_bits());

  initial forever #12.5 i_ref_clk = ~i_ref_clk;

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task wr(input [5:0] a, input [31:0] d, input [3:0] b);
    begin
      @(negedge i_ref_clk);
      i_wr_en = 1'b1;
      i_addr = a;
      i_wdata = d;
      i_be = b;
      @(negedge i_ref_clk);
      i_wr_en = 1'b0;
    end
  endtask
  task rd(input [5:0] a);
    begin
      @(negedge i_ref_clk);
      i_rd_en = 1'b1;
      i_addr = a;
      @(negedge i_ref_clk);
      i_rd_en = 1'b0;
      rv = o_rdata;
    end
  endtask
  task fire(input integer n);
    begin
      @(negedge i_ref_clk);
      i_cu_cmd_irq_done = (n == 0);
      i_rx_frame_done = (n == 1);
      i_cu_state = (n == 2) ? 2'h0 : 2'h2;
      i_rx_state = (n == 3) ? 4'h1 : 4'h4;
      @(negedge i_ref_clk);
      i_cu_cmd_irq_done = 1'b0;
      i_rx_frame_done = 1'b0;
      i_cu_state = 2'h2;
      i_rx_state = 4'h4;
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    begin
      i_modem_irq = 1'b1;
      i_pause = 1'b1;
      rd(6'h00);
      chk("status_word", rv & 32'hfdffffff, 32'h01000190);
      chk("pin", o_int_line_oe, 1);
      i_modem_irq = 1'b0;
      i_pause = 1'b0;
    end
  endtask
  task t_events;
    begin
      wr(6'h00, 32'h0, 4'h8);
      for (k = 0; k < 4; k = k + 1)
        fire(k);
      rd(6'h00);
      chk("flags", rv[15:12], 4'hf);
      chk("irq", o_lan_irq, 1);
      wr(6'h00, 32'hfc00, 4'h2);
      chk("irq", o_lan_irq, 0);
      for (k = 0; k < 4; k = k + 1) begin
        wr(6'h00, 32'h1 << (31 - k), 4'h8);
        fire(k);
        rd(6'h00);
        chk("flag", rv[15 - k], 1);
        chk("irq", o_lan_irq, 0);
        wr(6'h00, 32'h1 << (15 - k), 4'h2);
      end
    end
  endtask
  task t_soft;
    begin
      wr(6'h00, 32'h02000000, 4'h8);
      rd(6'h00);
      chk("soft_flag", rv[10], 1);
      chk("irq", o_lan_irq, 1);
      wr(6'h00, 32'h01000000, 4'h8);
      chk("irq", o_lan_irq, 0);
      wr(6'h00, 32'h400, 4'h2);
      wr(6'h00, 32'h0, 4'h8);
      rd(6'h00);
      chk("soft_flag", rv[10], 0);
      wr(6'h00, 32'h06000000, 4'h8);
      rd(6'h00);
      chk("soft_flag", rv[10], 1);
      chk("irq", o_lan_irq, 0);
    end
  endtask
  task t_unit;
    begin
      wr(6'h00, 32'h00590000, 4'h4);
      chk("strobe", o_unit_cmd_strobe, 1);
      chk("cmds", {o_cu_cmd, o_rx_cmd}, 8'h59);
      i_cmd_taken = 1'b1;
      @(negedge i_ref_clk);
      i_cmd_taken = 1'b0;
      chk("cmds", {o_cu_cmd, o_rx_cmd}, 8'h00);
      wr(6'h04, 32'h12345678, 4'hf);
      wr(6'h04, 32'hab0000cd, 4'h9);
      rd(6'h04);
      chk("ptr", rv, 32'hab3456cd);
    end
  endtask
  task t_port;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        wr(6'h08, 32'h5a5a5a50 | k, 4'hf);
        chk("sel", {o_port_soft_reset, o_port_self_test, o_port_sel_reset, o_port_dump},
          4'h8 >> k);
        chk("arg", o_port_arg, 28'h5a5a5a5);
      end
      wr(6'h08, 32'h0, 4'h1);
      chk("sel", o_port_soft_reset, 0);
      rd(6'h08);
      chk("port", rv, 0);
    end
  endtask
  task t_rxcnt;
    begin
      i_rx_dma_valid = 1'b1;
      i_rx_dma_bytes = 3'h3;
      @(negedge i_ref_clk);
      i_rx_dma_bytes = 3'h7;
      @(negedge i_ref_clk);
      i_rx_dma_valid = 1'b0;
      wr(6'h14, 32'hffffffff, 4'hf);
      rd(6'h14);
      chk("count", rv, 32'ha);
    end
  endtask
  // Reserved opcode and partial writes must not start a frame
  task t_mg_refuse;
    begin
      wr(6'h10, 32'h2c000000, 4'hf);
      repeat (40) @(negedge i_ref_clk);
      rd(6'h10);
      chk("refused", rv, 32'h2c000000);
      chk("mdc", o_mdc, 0);
      wr(6'h10, 32'h24000000, 4'h7);
      rd(6'h10);
      chk("partial", rv, 32'h2c000000);
    end
  endtask
  // Second write lands while busy and must leave the frame alone
  task mg(input [31:0] d, input [15:0] e);
    integer n;
    begin
      arm = 1'b1;
      @(negedge i_ref_clk);
      arm = 1'b0;
      wr(6'h10, d, 4'hf);
      wr(6'h10, d ^ 32'hffff, 4'hf);
      rd(6'h10);
      chk("ready", rv[28], 0);
      for (n = 0; n < 700 && rv[28] !== 1'b1; n = n + 1)
        rd(6'h10);
      chk("ready", rv[28], 1);
      chk("data", rv[15:0], e);
      chk("head", frame[0:31], 32'hffffffff);
      chk("cmd", frame[32:45], {2'h1, d[27:16]});
      chk("line", frame[48:63], e);
      rd(6'h00);
      chk("phy_flag", rv[11], 1);
      chk("irq", o_lan_irq, d[29]);
      wr(6'h00, 32'h800, 4'h2);
    end
  endtask

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  always @(posedge i_ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 10000) begin
      mismatches = mismatches + 1;
      complete_run;
    end
  end
  initial begin
    repeat (12) @(negedge i_ref_clk);
    i_rst_n = 1'b1;
    t_reset;
    t_events;
    t_soft;
    t_unit;
    t_port;
    t_rxcnt;
    t_mg_refuse;
    wr(6'h00, 32'hfc00, 4'h2);
    wr(6'h00, 32'h0, 4'h8);
    mg(32'h2573a5c3, 16'ha5c3);
    mg(32'h0be20000, 16'h3c96);
    complete_run;
  end
endmodule
